// File: common/usw_regs.vh
// register map, field positions and timing constants of the suspend/wakeup/stall controller
`ifndef USW_REGS_VH
`define USW_REGS_VH
// register indices; byte address is four times the index
`define USW_IDX_ENDPOINT_STALL 5'h09
`define USW_IDX_ENDPOINT_IRQ_FLAG 5'h0b
`define USW_IDX_ENDPOINT_IRQ_ENABLE 5'h0c
`define USW_IDX_USB_IRQ_FLAG 5'h0d
`define USW_IDX_USB_IRQ_ENABLE 5'h0e
`define USW_IDX_USB_CONTROL 5'h0f
`define USW_IDX_CPU_CONTROL 5'h10
// endpoint stall register fields
`define USW_BIT_STALL_EP0_IN 0
`define USW_BIT_STALL_EP0_OUT 1
`define USW_BIT_STALL_EP1_OUT 2
`define USW_BIT_STALL_EP2_IN 3
`define USW_BIT_STALL_EP3_IN 4
`define USW_BIT_STALL_STATUS 5
`define USW_BIT_STATUS_ACK 6
// endpoint irq fields
`define USW_BIT_SETUP_AVAIL 5
// usb irq fields
`define USW_BIT_OSC_READY 0
`define USW_BIT_WAKEUP_DONE 1
// usb control fields
`define USW_BIT_REMOTE_WAKEUP 2
`define USW_BIT_POWER_DOWN 4
`define USW_BIT_CHIP_RESET 5
`define USW_BIT_HOST_OSC_START 7
// cpu control fields
`define USW_BIT_CPU_IRQ_EN 0
// reset value of every register
`define USW_RESET_BYTE 8'h00
// bus responses
`define USW_RESP_OKAY 2'h0
`define USW_RESP_DECERR 2'h3
// timing
`define USW_CLK_KHZ 125000
`define USW_J_IDLE_MS 5
`define USW_K_DRIVE_MS 10
// the two intervals above counted in clk_sys cycles
`define USW_J_IDLE_CYC 21'h98968
`define USW_K_DRIVE_CYC 21'h1312d0
`endif

// File: hw/usw_ctrl.v
// suspend, power-down, remote wakeup and endpoint stall control with an axi4-lite register slave
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "usw_regs.vh"

// Functional notes
// - power-down is entered only on a rising edge of the power-down bit
// - power-down stops the oscillator, watches D+, accepts only control register writes
// - clearing power-down restarts oscillator; oscillator-ready flag rises once stable
// - D+ activity wakes from power-down only when host oscillator start is enabled
// - wakeup-done enable, cleared by all resets, read-only while powered down
// - wakeup-done flag set when K interval ends; write one clears; all resets clear
// - remote wakeup bit starts signalling; only power-on clears; writable in power-down
// - wait 5 ms idle J, drive K 10 ms, release bus, set done flag
// - wakeup requested from power-down waits for stable oscillator before signalling
// - clearing remote wakeup during K still completes the full K interval
// - remote wakeup left set repeats 5 ms J then 10 ms K
// - stall bit 0 stalls endpoint 0 IN; SETUP and resets clear it
// - stall bit 1 stalls endpoint 0 OUT; SETUP and resets clear it
// - stall bit 2 stalls endpoint 1 OUT; cleared by cpu or reset
// - stall bit 3 stalls endpoint 2 IN; cleared by cpu or reset
// - stall bit 4 stalls endpoint 3 IN; not cleared by SETUP
// - stall bit 5 stalls status stage; SETUP and resets clear it
// - status stage answered with NAK until ack or stall bit set
// - setup-available enable, cleared by all resets, read-only while powered down
module usw_ctrl #(
  parameter ADDR_W = 8,
  parameter CNT_W = 21,
  parameter [CNT_W-1:0] J_IDLE_CYC = `USW_J_IDLE_CYC,
  parameter [CNT_W-1:0] K_DRIVE_CYC = `USW_K_DRIVE_CYC
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire busReset,
  input wire setupToken,
  input wire setupDataAvail,
  input wire oscStablePin,
  input wire dplusIn,
  output reg dplusOut,
  output reg dplusOe,
  output reg dminusOut,
  output reg dminusOe,
  output reg oscillatorRun,
  output reg [5:0] endpointStall,
  output reg statusStageAck,
  output reg statusStageNak,
  output reg lowPower,
  output reg irqOut
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_OSC_WAIT = 4'h2;
  localparam [3:0] ST_J_IDLE = 4'h4;
  localparam [3:0] ST_K_DRIVE = 4'h8;

  reg [2:0] oscSync;
  reg [2:0] dplusSync;
  reg oscStable;
  reg dplusLevel;
  reg dplusPrev;
  reg oscillatorReady;
  reg oscReadyPrev;
  reg powerDownPrev;

  reg [7:0] endpointStallReg;
  reg setupAvailFlag;
  reg setupAvailIrqEnable;
  reg oscReadyFlag;
  reg wakeupDoneFlag;
  reg oscReadyIrqEnable;
  reg wakeupDoneIrqEnable;
  reg remoteWakeupRequest;
  reg powerDownBit;
  reg chipResetBit;
  reg hostActivityOscStartEn;
  reg cpuIrqEnable;

  reg [3:0] wakeState;
  reg [CNT_W-1:0] wakeCount;
  reg wakeDonePulse;

  reg awHeld;
  reg wHeld;
  reg [4:0] awIndex;
  reg awMapped;
  reg [7:0] wByte;
  reg wLane0;

  wire softReset = chipResetBit | busReset;
  wire writeNow = awHeld & wHeld & ~s_axi_bvalid;
  wire writeByte = writeNow & awMapped & wLane0;
  // power-down leaves only the control registers writable
  wire writeAllowed = ~lowPower;
  wire wrStall = writeByte & writeAllowed & (awIndex == `USW_IDX_ENDPOINT_STALL);
  wire wrEpFlag = writeByte & writeAllowed & (awIndex == `USW_IDX_ENDPOINT_IRQ_FLAG);
  wire wrEpEn = writeByte & writeAllowed & (awIndex == `USW_IDX_ENDPOINT_IRQ_ENABLE);
  wire wrUsbFlag = writeByte & writeAllowed & (awIndex == `USW_IDX_USB_IRQ_FLAG);
  wire wrUsbEn = writeByte & writeAllowed & (awIndex == `USW_IDX_USB_IRQ_ENABLE);
  wire wrCtl = writeByte & (awIndex == `USW_IDX_USB_CONTROL);
  wire wrCpu = writeByte & (awIndex == `USW_IDX_CPU_CONTROL);

  function mapped;
    input [4:0] idx;
    begin
      mapped = (idx == `USW_IDX_ENDPOINT_STALL) | (idx == `USW_IDX_ENDPOINT_IRQ_FLAG) |
        (idx == `USW_IDX_ENDPOINT_IRQ_ENABLE) | (idx == `USW_IDX_USB_IRQ_FLAG) |
        (idx == `USW_IDX_USB_IRQ_ENABLE) | (idx == `USW_IDX_USB_CONTROL) |
        (idx == `USW_IDX_CPU_CONTROL);
    end
  endfunction

  wire [4:0] arIndex = s_axi_araddr[6:2];
  wire arMapped = mapped(arIndex) && (s_axi_araddr[ADDR_W-1:7] == 0) && (s_axi_araddr[1:0] == 2'h0);

  reg [7:0] readByte;
  always @* begin
    readByte = `USW_RESET_BYTE;
    case (arIndex)
      `USW_IDX_ENDPOINT_STALL: readByte = endpointStallReg;
      `USW_IDX_ENDPOINT_IRQ_FLAG: readByte[`USW_BIT_SETUP_AVAIL] = setupAvailFlag;
      `USW_IDX_ENDPOINT_IRQ_ENABLE: readByte[`USW_BIT_SETUP_AVAIL] = setupAvailIrqEnable;
      `USW_IDX_USB_IRQ_FLAG: begin
        readByte[`USW_BIT_OSC_READY] = oscReadyFlag;
        readByte[`USW_BIT_WAKEUP_DONE] = wakeupDoneFlag;
      end
      `USW_IDX_USB_IRQ_ENABLE: begin
        readByte[`USW_BIT_OSC_READY] = oscReadyIrqEnable;
        readByte[`USW_BIT_WAKEUP_DONE] = wakeupDoneIrqEnable;
      end
      `USW_IDX_USB_CONTROL: begin
        readByte[`USW_BIT_REMOTE_WAKEUP] = remoteWakeupRequest;
        readByte[`USW_BIT_POWER_DOWN] = powerDownBit;
        readByte[`USW_BIT_CHIP_RESET] = chipResetBit;
        readByte[`USW_BIT_HOST_OSC_START] = hostActivityOscStartEn;
      end
      `USW_IDX_CPU_CONTROL: readByte[`USW_BIT_CPU_IRQ_EN] = cpuIrqEnable;
      default: readByte = `USW_RESET_BYTE;
    endcase
  end

  // axi4-lite slave: address and data taken in either order, response after both
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USW_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `USW_RESP_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIndex <= 5'h00;
      awMapped <= 1'b0;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
        awIndex <= s_axi_awaddr[6:2];
        awMapped <= mapped(s_axi_awaddr[6:2]) && (s_axi_awaddr[ADDR_W-1:7] == 0) &&
          (s_axi_awaddr[1:0] == 2'h0);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
        wByte <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
      end
      if (writeNow) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awMapped ? `USW_RESP_OKAY : `USW_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, arMapped ? readByte : 8'h00};
        s_axi_rresp <= arMapped ? `USW_RESP_OKAY : `USW_RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // pin synchronisers; a level counts once stages two and three agree
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      oscSync <= 3'h0;
      dplusSync <= 3'h7;
      oscStable <= 1'b0;
      dplusLevel <= 1'b1;
      dplusPrev <= 1'b1;
    end else begin
      oscSync <= {oscSync[1:0], oscStablePin};
      dplusSync <= {dplusSync[1:0], dplusIn};
      if (oscSync[1] == oscSync[2])
        oscStable <= oscSync[2];
      if (dplusSync[1] == dplusSync[2])
        dplusLevel <= dplusSync[2];
      dplusPrev <= dplusLevel;
    end
  end

  // power-down and oscillator control
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      powerDownPrev <= 1'b0;
      lowPower <= 1'b0;
      oscillatorRun <= 1'b1;
      oscillatorReady <= 1'b0;
      oscReadyPrev <= 1'b0;
    end else begin
      powerDownPrev <= powerDownBit;
      if (powerDownBit && !powerDownPrev) begin
        lowPower <= 1'b1;
        oscillatorRun <= 1'b0;
      end else if (lowPower && !powerDownBit) begin
        lowPower <= 1'b0;
        oscillatorRun <= 1'b1;
      end else if (lowPower && hostActivityOscStartEn && (dplusLevel != dplusPrev)) begin
        lowPower <= 1'b0;
        oscillatorRun <= 1'b1;
      end
      oscillatorReady <= oscStable & oscillatorRun;
      oscReadyPrev <= oscillatorReady;
    end
  end

  // remote wakeup signalling
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      wakeState <= ST_IDLE;
      wakeCount <= {CNT_W{1'b0}};
      wakeDonePulse <= 1'b0;
      dplusOut <= 1'b1;
      dplusOe <= 1'b0;
      dminusOut <= 1'b0;
      dminusOe <= 1'b0;
    end else begin
      wakeDonePulse <= 1'b0;
      case (wakeState)
        ST_IDLE: begin
          wakeCount <= {CNT_W{1'b0}};
          if (remoteWakeupRequest)
            wakeState <= oscillatorReady ? ST_J_IDLE : ST_OSC_WAIT;
        end
        ST_OSC_WAIT: begin
          if (!remoteWakeupRequest)
            wakeState <= ST_IDLE;
          else if (oscillatorReady)
            wakeState <= ST_J_IDLE;
        end
        ST_J_IDLE: begin
          if (!remoteWakeupRequest) begin
            wakeState <= ST_IDLE;
          end else if (!dplusLevel) begin
            wakeCount <= {CNT_W{1'b0}};
          end else if (wakeCount == J_IDLE_CYC - 1'b1) begin
            wakeCount <= {CNT_W{1'b0}};
            wakeState <= ST_K_DRIVE;
            dplusOut <= 1'b0;
            dminusOut <= 1'b1;
            dplusOe <= 1'b1;
            dminusOe <= 1'b1;
          end else begin
            wakeCount <= wakeCount + 1'b1;
          end
        end
        ST_K_DRIVE: begin
          // request bit is not sampled until the interval is over
          if (wakeCount == K_DRIVE_CYC - 1'b1) begin
            wakeCount <= {CNT_W{1'b0}};
            wakeDonePulse <= 1'b1;
            dplusOut <= 1'b1;
            dminusOut <= 1'b0;
            dplusOe <= 1'b0;
            dminusOe <= 1'b0;
            wakeState <= remoteWakeupRequest ? ST_J_IDLE : ST_IDLE;
          end else begin
            wakeCount <= wakeCount + 1'b1;
          end
        end
        default: wakeState <= ST_IDLE;
      endcase
    end
  end

  // software registers; hardware set wins over a same-cycle write-one clear, soft reset wins over both
  reg [7:0] next_stall;
  always @* begin
    next_stall = endpointStallReg;
    if (wrStall)
      next_stall = {1'b0, wByte[6:0]};
    if (setupToken) begin
      next_stall[`USW_BIT_STALL_EP0_IN] = 1'b0;
      next_stall[`USW_BIT_STALL_EP0_OUT] = 1'b0;
      next_stall[`USW_BIT_STALL_STATUS] = 1'b0;
      next_stall[`USW_BIT_STATUS_ACK] = 1'b0;
    end
    if (softReset)
      next_stall = `USW_RESET_BYTE;
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      endpointStallReg <= `USW_RESET_BYTE;
      endpointStall <= 6'h00;
      statusStageAck <= 1'b0;
      statusStageNak <= 1'b1;
      setupAvailFlag <= 1'b0;
      setupAvailIrqEnable <= 1'b0;
      oscReadyFlag <= 1'b0;
      wakeupDoneFlag <= 1'b0;
      oscReadyIrqEnable <= 1'b0;
      wakeupDoneIrqEnable <= 1'b0;
      remoteWakeupRequest <= 1'b0;
      powerDownBit <= 1'b0;
      chipResetBit <= 1'b0;
      hostActivityOscStartEn <= 1'b0;
      cpuIrqEnable <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      endpointStallReg <= next_stall;
      endpointStall <= next_stall[5:0];
      statusStageAck <= next_stall[`USW_BIT_STATUS_ACK];
      statusStageNak <= ~(next_stall[`USW_BIT_STATUS_ACK] | next_stall[`USW_BIT_STALL_STATUS]);
      if (wrCtl) begin
        remoteWakeupRequest <= wByte[`USW_BIT_REMOTE_WAKEUP];
        powerDownBit <= wByte[`USW_BIT_POWER_DOWN];
        chipResetBit <= wByte[`USW_BIT_CHIP_RESET];
        hostActivityOscStartEn <= wByte[`USW_BIT_HOST_OSC_START];
      end
      if (wrCpu)
        cpuIrqEnable <= wByte[`USW_BIT_CPU_IRQ_EN];
      if (softReset) begin
        setupAvailIrqEnable <= 1'b0;
        oscReadyIrqEnable <= 1'b0;
        wakeupDoneIrqEnable <= 1'b0;
        setupAvailFlag <= 1'b0;
        oscReadyFlag <= 1'b0;
        wakeupDoneFlag <= 1'b0;
      end else begin
        if (wrEpEn)
          setupAvailIrqEnable <= wByte[`USW_BIT_SETUP_AVAIL];
        if (wrUsbEn) begin
          oscReadyIrqEnable <= wByte[`USW_BIT_OSC_READY];
          wakeupDoneIrqEnable <= wByte[`USW_BIT_WAKEUP_DONE];
        end
        if (setupDataAvail)
          setupAvailFlag <= 1'b1;
        else if (wrEpFlag && wByte[`USW_BIT_SETUP_AVAIL])
          setupAvailFlag <= 1'b0;
        if (oscillatorReady && !oscReadyPrev)
          oscReadyFlag <= 1'b1;
        else if (wrUsbFlag && wByte[`USW_BIT_OSC_READY])
          oscReadyFlag <= 1'b0;
        if (wakeDonePulse)
          wakeupDoneFlag <= 1'b1;
        else if (wrUsbFlag && wByte[`USW_BIT_WAKEUP_DONE])
          wakeupDoneFlag <= 1'b0;
      end
      irqOut <= cpuIrqEnable & ((setupAvailFlag & setupAvailIrqEnable) | (oscReadyFlag & oscReadyIrqEnable) |
        (wakeupDoneFlag & wakeupDoneIrqEnable));
    end
  end
endmodule
`default_nettype wire

// File: sim/usw_ctrl_sva.sv
// port assertions for the suspend, wakeup and stall controller
`timescale 1ns/10ps
`default_nettype none
module usw_ctrl_chk #(
  parameter int K_DRIVE_CYC = 40
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic busReset,
  input wire logic setupToken,
  input wire logic dplusOut,
  input wire logic dplusOe,
  input wire logic dminusOut,
  input wire logic dminusOe,
  input wire logic oscillatorRun,
  input wire logic [5:0] endpointStall,
  input wire logic statusStageAck,
  input wire logic statusStageNak,
  input wire logic lowPower
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [31:0] kCnt;
  // length of the current k drive
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      kCnt <= 32'h0;
    end else begin
      kCnt <= dplusOe ? kCnt + 32'h1 : 32'h0;
    end
  end
  kstate_levels_a: assert property (dplusOe |-> !dplusOut && dminusOut && dminusOe)
    else $error("k state levels wrong");
  kdrive_span_a: assert property ($fell(dplusOe) |-> kCnt == K_DRIVE_CYC)
    else $error("k drive length wrong");
  osc_stopped_a: assert property (lowPower |-> !oscillatorRun)
    else $error("oscillator runs in power down");
  k_needs_osc_a: assert property (dplusOe |-> oscillatorRun && !lowPower)
    else $error("k driven without oscillator");
  status_nak_a: assert property (statusStageNak == !(statusStageAck || endpointStall[5]))
    else $error("status nak wrong");
  setup_clear_a: assert property (setupToken && !busReset |=> endpointStall[1:0] == 2'h0 && !endpointStall[5])
    else $error("setup left ep0 stall");
  setup_keep_a: assert property (setupToken && !busReset |=> $stable(endpointStall[4:2]))
    else $error("setup touched halt stalls");
  bus_reset_a: assert property (busReset |=> endpointStall == 6'h0 && !statusStageAck)
    else $error("bus reset left stall bits");
  cover property ($fell(dplusOe));
  cover property ($rose(lowPower));
  cover property (setupToken && endpointStall[4:2] != 3'h0);
endmodule
bind usw_ctrl usw_ctrl_chk #(.K_DRIVE_CYC(K_DRIVE_CYC)) uChk (
  .clk_sys(clk_sys), .reset_n(reset_n), .busReset(busReset), .setupToken(setupToken),
  .dplusOut(dplusOut), .dplusOe(dplusOe), .dminusOut(dminusOut), .dminusOe(dminusOe),
  .oscillatorRun(oscillatorRun), .endpointStall(endpointStall), .statusStageAck(statusStageAck),
  .statusStageNak(statusStageNak), .lowPower(lowPower));
`default_nettype wire

// File: sim/usw_host_model.sv
// host side of the bus: pulled-up d+ line, host resume, k drive timing
`timescale 1ns/10ps
`default_nettype none
module usw_host_model (
  input wire logic clk_sys,
  input wire logic dplusOut,
  input wire logic dplusOe,
  input wire logic dminusOut,
  input wire logic dminusOe,
  input wire logic hostResume,
  output logic dplusIn,
  output int kLen,
  output int kCount
);
  int run;
  // released line floats to j through the pull-up; host resume pulls k
  assign dplusIn = dplusOe ? dplusOut : !hostResume;
  always @(posedge clk_sys) begin
    if (dplusOe && !dplusOut && dminusOe && dminusOut) begin
      run <= run + 1;
    end else if (run != 0) begin
      kLen <= run;
      kCount <= kCount + 1;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

// File: sim/usw_ctrl_tb.sv
// self-checking bench for the suspend, wakeup and stall controller
`timescale 1ns/10ps
`default_nettype none
`include "usw_regs.vh"
module usw_ctrl_tb;
  localparam logic [4:0] STL = `USW_IDX_ENDPOINT_STALL, EPF = `USW_IDX_ENDPOINT_IRQ_FLAG;
  localparam logic [4:0] EPE = `USW_IDX_ENDPOINT_IRQ_ENABLE, UF = `USW_IDX_USB_IRQ_FLAG;
  localparam logic [4:0] UE = `USW_IDX_USB_IRQ_ENABLE, UC = `USW_IDX_USB_CONTROL, CC = `USW_IDX_CPU_CONTROL;
  localparam logic [1:0] OK = `USW_RESP_OKAY, DE = `USW_RESP_DECERR;
  logic clk_sys = 1'b0;
  logic reset_n, busReset, setupToken, setupDataAvail, oscStablePin, hostResume;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, v;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic dplusIn, dplusOut, dplusOe, dminusOut, dminusOe, oscillatorRun, statusStageAck, statusStageNak;
  logic lowPower, irqOut;
  logic [5:0] endpointStall;
  logic [4:0] regs [6] = '{STL, EPF, EPE, UE, UC, CC};
  int kLen, kCount, n_fail, n_tests, cyc;
  always #4 clk_sys = ~clk_sys;
  usw_ctrl #(.J_IDLE_CYC(21'd20), .K_DRIVE_CYC(21'd40)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .busReset(busReset), .setupToken(setupToken), .setupDataAvail(setupDataAvail),
    .oscStablePin(oscStablePin), .dplusIn(dplusIn), .dplusOut(dplusOut), .dplusOe(dplusOe),
    .dminusOut(dminusOut), .dminusOe(dminusOe), .oscillatorRun(oscillatorRun), .endpointStall(endpointStall),
    .statusStageAck(statusStageAck), .statusStageNak(statusStageNak), .lowPower(lowPower), .irqOut(irqOut));
  usw_host_model host (.clk_sys(clk_sys), .dplusOut(dplusOut), .dplusOe(dplusOe), .dminusOut(dminusOut),
    .dminusOe(dminusOe), .hostResume(hostResume), .dplusIn(dplusIn), .kLen(kLen), .kCount(kCount));
  // oscillator settles one cycle after it is enabled
  always @(posedge clk_sys) begin
    oscStablePin <= oscillatorRun;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // setup clears ep0 stalls, status stall and status ack
  function automatic logic [7:0] afterSetup(input logic [7:0] s);
    return s & 8'h1c;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic a, w, b;
    a = 1'b0;
    w = 1'b0;
    b = 1'b0;
    awaddr <= {1'b0, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!b) begin
      @(posedge clk_sys);
      b = bvalid;
      if (awready && !a) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    chk("bresp", {30'h0, OK}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [4:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic a, r;
    a = 1'b0;
    r = 1'b0;
    araddr <= {1'b0, idx, 2'b00};
    arvalid <= 1'b1;
    while (!r) begin
      @(posedge clk_sys);
      if (arready && !a) begin
        a = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        r = 1'b1;
        chk("rdata", {24'h0, e}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
  endtask
  task automatic pulse(input int which);
    if (which == 0) setupToken <= 1'b1;
    else setupDataAvail <= 1'b1;
    tick(1);
    setupToken <= 1'b0;
    setupDataAvail <= 1'b0;
    tick(1);
  endtask
  initial begin
    {reset_n, busReset, setupToken, setupDataAvail, hostResume} <= 5'h00;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} <= '0;
    {bready, rready, wstrb} <= 6'h3f;
    {n_fail, n_tests} = '0;
    rnd = 32'd37;
    tick(4);
    reset_n <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00, OK);
    rd(5'h00, 8'h00, DE);
    rd(5'h11, 8'h00, DE);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      v = (i == 0) ? 8'h23 : (i == 1) ? 8'h7f : {1'b0, rnd[6:0]};
      wr(STL, v);
      rd(STL, v, OK);
      chk("stallPins", {26'h0, v[5:0]}, {26'h0, endpointStall});
      chk("statusNak", {31'h0, !(v[5] || v[6])}, {31'h0, statusStageNak});
      pulse(0);
      rd(STL, afterSetup(v), OK);
    end
    $display("stall bits done");
    wr(EPE, 8'h20);
    wr(CC, 8'h01);
    pulse(1);
    tick(2);
    chk("irqOut", 32'h1, {31'h0, irqOut});
    rd(EPF, 8'h20, OK);
    wr(CC, 8'h00);
    tick(2);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    wr(CC, 8'h01);
    wr(EPE, 8'h00);
    tick(2);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    wr(EPF, 8'h20);
    rd(EPF, 8'h00, OK);
    $display("setup irq done");
    wr(STL, 8'h7f);
    wr(UE, 8'h03);
    wr(UC, 8'h80);
    busReset <= 1'b1;
    tick(3);
    busReset <= 1'b0;
    tick(1);
    rd(STL, 8'h00, OK);
    rd(UE, 8'h00, OK);
    rd(UC, 8'h80, OK);
    wr(STL, 8'h1c);
    wr(UE, 8'h03);
    wr(UC, 8'ha0);
    rd(UC, 8'ha0, OK);
    rd(STL, 8'h00, OK);
    rd(UE, 8'h00, OK);
    wr(UC, 8'h80);
    $display("bus reset done");
    wr(UE, 8'h02);
    wr(UF, 8'h03);
    wr(UC, 8'h90);
    tick(3);
    chk("lowPower", 32'h1, {31'h0, lowPower});
    chk("oscRun", 32'h0, {31'h0, oscillatorRun});
    wr(STL, 8'h01);
    rd(STL, 8'h00, OK);
    wr(UE, 8'h00);
    rd(UE, 8'h02, OK);
    hostResume <= 1'b1;
    tick(3);
    hostResume <= 1'b0;
    tick(18);
    chk("lowPower", 32'h0, {31'h0, lowPower});
    wr(UF, 8'h03);
    wr(UC, 8'h00);
    wr(UC, 8'h10);
    tick(3);
    hostResume <= 1'b1;
    tick(3);
    hostResume <= 1'b0;
    tick(12);
    chk("lowPower", 32'h1, {31'h0, lowPower});
    wr(UC, 8'h04);
    while (kCount < 1) tick(1);
    tick(2);
    chk("kLen", 32'd40, kLen);
    rd(UF, 8'h03, OK);
    chk("irqOut", 32'h1, {31'h0, irqOut});
    wr(UF, 8'h02);
    rd(UF, 8'h01, OK);
    while (!dplusOe) tick(1);
    wr(UC, 8'h00);
    while (kCount < 2) tick(1);
    tick(2);
    chk("kLen", 32'd40, kLen);
    tick(100);
    chk("kCount", 32'd2, kCount);
    $display("power and wakeup done");
    end_of_test();
  end
endmodule
`default_nettype wire
